// ---- peripheral_mcu_instr_exec.sv ----
module peripheral_mcu_instr_exec (
    input wire logic clk,
    input wire logic rst_b,
    output logic [exec_pkg::PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic host_cs_b,
    input wire logic host_wr_b,
    input wire logic host_cd_sel,
    input wire logic [7:0] host_data_in,
    input wire logic output_buffer_full_flag,
    input wire logic test_input_zero,
    input wire logic test_input_one,
    input wire logic timer_overflow,
    input wire logic carry_in,
    input wire logic user_flag_zero,
    input wire logic [7:0] port2_write_data,
    input wire logic port2_write,
    input wire logic port2_bit7,
    output logic [7:0] port2_out,
    output logic [7:0] accumulator,
    output logic input_buffer_full_flag,
    output logic command_data_flag,
    output logic timer_overflow_flag,
    output logic irq_start,
    output logic input_irq_pending,
    output logic timer_irq_pending,
    output logic dma_request_out,
    output logic dma_enabled,
    output logic flags_enabled
);
    // ============================================================
    // pin synchronisers
    logic [4:0] pins_s;
    exec_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({host_cs_b, host_wr_b, test_input_zero, test_input_one, port2_bit7}),
        .sync_out(pins_s)
    );
    logic cs_b_s, wr_b_s, t0_s, t1_s, dma_acknowledge_in_s;
    assign cs_b_s = pins_s[4];
    assign wr_b_s = pins_s[3];
    assign t0_s = pins_s[2];
    assign t1_s = pins_s[1];
    assign dma_acknowledge_in_s = !pins_s[0]; // acknowledge pin is active low

    // ============================================================
    // state
    exec_pkg::exec_state_t st_q, st_d;
    logic [exec_pkg::PC_W-1:0] pc_q, pc_d;
    logic [7:0] op_q, op_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] regs_q [0:7];
    logic [7:0] regs_d [0:7];
    logic ibf_q, ibf_d;
    logic cdf_q, cdf_d;
    logic tf_q, tf_d;
    logic ien_q, ien_d;
    logic ten_q, ten_d;
    logic ipend_q, ipend_d;
    logic tpend_q, tpend_d;
    logic dma_q, dma_d;
    logic flg_q, flg_d;
    logic drq_q, drq_d;
    logic [7:0] p2_q, p2_d;
    logic [7:0] dbb_q, dbb_d;
    logic wr_prev_q, wr_prev_d;
    logic irq_q, irq_d;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [exec_pkg::DMEM_AW-1:0] mem_addr;

    // ============================================================
    // helpers
    function automatic logic [exec_pkg::PC_W-1:0] page_load(input logic [exec_pkg::PC_W-1:0] pc,
                                                           input logic [7:0] low);
        page_load = {pc[exec_pkg::PC_W-1:8], low};
    endfunction

    function automatic logic [exec_pkg::PC_W-1:0] pc_inc(input logic [exec_pkg::PC_W-1:0] pc);
        pc_inc = pc + 11'h001;
    endfunction

    // internal data memory, address from R0/R1 bits 0-5
    assign mem_addr = regs_q[{2'b00, op_q[0]}][exec_pkg::DMEM_AW-1:0];
    exec_dmem u_dmem (
        .clk(clk),
        .raddr(mem_addr),
        .rdata(mem_rdata),
        .we(mem_we),
        .waddr(mem_addr),
        .wdata(mem_wdata)
    );

    // host strobes, DMA acknowledge forces select and command low
    logic host_sel, host_cd, host_wr_edge;
    assign host_sel = (dma_q && dma_acknowledge_in_s) ? 1'b1 : !cs_b_s;
    assign host_cd = (dma_q && dma_acknowledge_in_s) ? 1'b0 : host_cd_sel;
    assign host_wr_edge = host_sel && !wr_b_s && wr_prev_q;

    // branch condition for the two-byte jumps
    logic cond;
    logic [7:0] rsel_dec;
    assign rsel_dec = regs_q[op_q[2:0]] - 8'h01;
    always_comb begin
        cond = 1'b0;
        unique case (1'b1)
            (op_q == exec_pkg::OP_INPUT_EMPTY_JUMP): cond = !ibf_q;
            (op_q == exec_pkg::OP_OUTPUT_FULL_JUMP): cond = output_buffer_full_flag;
            (op_q == exec_pkg::OP_JC): cond = carry_in;
            (op_q == exec_pkg::OP_JNC): cond = !carry_in;
            (op_q == exec_pkg::OP_JF0): cond = user_flag_zero;
            (op_q == exec_pkg::OP_JF1): cond = cdf_q;
            (op_q == exec_pkg::OP_JTF): cond = tf_q;
            (op_q == exec_pkg::OP_JT0): cond = t0_s;
            (op_q == exec_pkg::OP_JNT0): cond = !t0_s;
            (op_q == exec_pkg::OP_JT1): cond = t1_s;
            (op_q == exec_pkg::OP_JNT1): cond = !t1_s;
            (op_q[4:0] == exec_pkg::GRP_JB_LOW): cond = acc_q[op_q[7:5]];
            (op_q[7:3] == exec_pkg::GRP_DECREMENT_BRANCH_NONZERO): cond = (rsel_dec != 8'h00);
            default: cond = 1'b0;
        endcase
    end

    // ============================================================
    // next-state logic
    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        op_d = op_q;
        acc_d = acc_q;
        regs_d = regs_q;
        ibf_d = ibf_q;
        cdf_d = cdf_q;
        tf_d = tf_q;
        ien_d = ien_q;
        ten_d = ten_q;
        ipend_d = ipend_q;
        tpend_d = tpend_q;
        dma_d = dma_q;
        flg_d = flg_q;
        drq_d = drq_q;
        p2_d = p2_q;
        dbb_d = dbb_q;
        wr_prev_d = wr_b_s || !host_sel;
        irq_d = 1'b0;
        mem_we = 1'b0;
        mem_wdata = mem_rdata + 8'h01;
        if (port2_write) begin
            p2_d = port2_write_data;
        end
        unique case (st_q)
            exec_pkg::ST_FETCH: begin
                op_d = prog_data;
                pc_d = pc_inc(pc_q);
                if (prog_data[7:1] == exec_pkg::GRP_INC_IND) begin
                    st_d = exec_pkg::ST_MEM;
                end else if (prog_data == exec_pkg::OP_DEC_A) begin
                    acc_d = acc_q - 8'h01;
                end else if (prog_data == exec_pkg::OP_INC_A) begin
                    acc_d = acc_q + 8'h01;
                end else if (prog_data[7:3] == exec_pkg::GRP_DEC_R) begin
                    regs_d[prog_data[2:0]] = regs_q[prog_data[2:0]] - 8'h01;
                end else if (prog_data[7:3] == exec_pkg::GRP_INC_R) begin
                    regs_d[prog_data[2:0]] = regs_q[prog_data[2:0]] + 8'h01;
                end else if (prog_data == exec_pkg::OP_EN_I) begin
                    ien_d = 1'b1;
                end else if (prog_data == exec_pkg::OP_INPUT_IRQ_DISABLE) begin
                    ien_d = 1'b0;
                end else if (prog_data == exec_pkg::OP_TIMER_IRQ_ENABLE) begin
                    ten_d = 1'b1;
                end else if (prog_data == exec_pkg::OP_TIMER_IRQ_DISABLE) begin
                    ten_d = 1'b0;
                    tpend_d = 1'b0;
                end else if (prog_data == exec_pkg::OP_EN_DMA) begin
                    dma_d = 1'b1;
                end else if (prog_data == exec_pkg::OP_EN_FLAGS) begin
                    flg_d = 1'b1;
                end else if (prog_data == exec_pkg::OP_IN_DBB) begin
                    acc_d = dbb_q;
                    ibf_d = 1'b0;
                end else if (prog_data == exec_pkg::OP_INDIRECT_PAGE_JUMP) begin
                    st_d = exec_pkg::ST_OPER;
                end else if (prog_data[4:0] == exec_pkg::GRP_JMP_LOW ||
                             prog_data[4:0] == exec_pkg::GRP_JB_LOW ||
                             prog_data[7:3] == exec_pkg::GRP_DECREMENT_BRANCH_NONZERO ||
                             prog_data[3:0] == 4'h6) begin
                    st_d = exec_pkg::ST_OPER;
                end
            end
            exec_pkg::ST_OPER: begin
                st_d = exec_pkg::ST_FETCH;
                if (op_q == exec_pkg::OP_INDIRECT_PAGE_JUMP) begin
                    pc_d = page_load(pc_q, prog_data);
                end else if (op_q[4:0] == exec_pkg::GRP_JMP_LOW) begin
                    pc_d = {pc_q[10], op_q[6:5], prog_data};
                end else begin
                    if (op_q[7:3] == exec_pkg::GRP_DECREMENT_BRANCH_NONZERO) begin
                        regs_d[op_q[2:0]] = rsel_dec;
                    end
                    if (op_q == exec_pkg::OP_JTF) begin
                        tf_d = 1'b0;
                    end
                    pc_d = cond ? page_load(pc_q, prog_data) : pc_inc(pc_q);
                end
            end
            exec_pkg::ST_MEM: begin
                mem_we = 1'b1;
                st_d = exec_pkg::ST_FETCH;
            end
            default: st_d = exec_pkg::ST_FETCH;
        endcase
        // host write latches buffer and request; set wins over read clear
        if (host_wr_edge) begin
            dbb_d = host_data_in;
            ibf_d = 1'b1;
            cdf_d = host_cd;
            ipend_d = 1'b1;
        end
        if (timer_overflow) begin
            tf_d = 1'b1;
            if (ten_d) begin
                tpend_d = 1'b1;
            end
        end
        // acknowledge clears request; request raised when IN DBB is fetched while buffer empty
        if (dma_q) begin
            if (dma_acknowledge_in_s) begin
                drq_d = 1'b0;
            end else if (!ibf_q && st_q == exec_pkg::ST_FETCH && prog_data == exec_pkg::OP_IN_DBB) begin
                drq_d = 1'b1;
            end
        end
        // interrupt start on enabled pending request
        if (ien_q && ipend_q) begin
            irq_d = 1'b1;
            ipend_d = host_wr_edge;
        end else if (ten_q && tpend_q) begin
            irq_d = 1'b1;
            tpend_d = timer_overflow;
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= exec_pkg::ST_FETCH;
            pc_q <= exec_pkg::PC_RESET;
            op_q <= 8'h00;
            acc_q <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= 8'h00;
            end
            ibf_q <= 1'b0;
            cdf_q <= 1'b0;
            tf_q <= 1'b0;
            ien_q <= 1'b0;
            ten_q <= 1'b0;
            ipend_q <= 1'b0;
            tpend_q <= 1'b0;
            dma_q <= 1'b0;
            flg_q <= 1'b0;
            drq_q <= 1'b0;
            p2_q <= exec_pkg::P2_RESET;
            dbb_q <= 8'h00;
            wr_prev_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pc_q <= pc_d;
            op_q <= op_d;
            acc_q <= acc_d;
            regs_q <= regs_d;
            ibf_q <= ibf_d;
            cdf_q <= cdf_d;
            tf_q <= tf_d;
            ien_q <= ien_d;
            ten_q <= ten_d;
            ipend_q <= ipend_d;
            tpend_q <= tpend_d;
            dma_q <= dma_d;
            flg_q <= flg_d;
            drq_q <= drq_d;
            p2_q <= p2_d;
            dbb_q <= dbb_d;
            wr_prev_q <= wr_prev_d;
            irq_q <= irq_d;
        end
    end

    // ============================================================
    // outputs
    // indirect jump addresses page byte at accumulator
    assign prog_addr = (st_q == exec_pkg::ST_OPER && op_q == exec_pkg::OP_INDIRECT_PAGE_JUMP) ?
                       page_load(pc_q, acc_q) : pc_q;
    // port 2 with flag and request routing
    always_comb begin
        port2_out = p2_q;
        if (flg_q) begin
            port2_out[exec_pkg::P2_OBF_BIT] = p2_q[exec_pkg::P2_OBF_BIT] & output_buffer_full_flag;
            port2_out[exec_pkg::P2_IBF_BIT] = p2_q[exec_pkg::P2_IBF_BIT] & !ibf_q;
        end
        if (dma_q) begin
            port2_out[exec_pkg::P2_DRQ_BIT] = drq_q;
        end
    end
    assign accumulator = acc_q;
    assign input_buffer_full_flag = ibf_q;
    assign command_data_flag = cdf_q;
    assign timer_overflow_flag = tf_q;
    assign irq_start = irq_q;
    assign input_irq_pending = ipend_q;
    assign timer_irq_pending = tpend_q;
    assign dma_request_out = drq_q;
    assign dma_enabled = dma_q;
    assign flags_enabled = flg_q;
endmodule

// ---- exec_pkg.sv ----
package exec_pkg;
    // opcodes, fixed bits
    localparam logic [7:0] OP_DEC_A = 8'h07;
    localparam logic [7:0] OP_INC_A = 8'h17;
    localparam logic [7:0] OP_EN_I = 8'h05;
    localparam logic [7:0] OP_INPUT_IRQ_DISABLE = 8'h15;
    localparam logic [7:0] OP_TIMER_IRQ_ENABLE = 8'h25;
    localparam logic [7:0] OP_TIMER_IRQ_DISABLE = 8'h35;
    localparam logic [7:0] OP_EN_DMA = 8'hE5;
    localparam logic [7:0] OP_EN_FLAGS = 8'hF5;
    localparam logic [7:0] OP_IN_DBB = 8'h22;
    localparam logic [7:0] OP_INPUT_EMPTY_JUMP = 8'hD6;
    localparam logic [7:0] OP_OUTPUT_FULL_JUMP = 8'h86;
    localparam logic [7:0] OP_JC = 8'hF6;
    localparam logic [7:0] OP_JNC = 8'hE6;
    localparam logic [7:0] OP_JF0 = 8'hB6;
    localparam logic [7:0] OP_JF1 = 8'h76;
    localparam logic [7:0] OP_JTF = 8'h16;
    localparam logic [7:0] OP_JT0 = 8'h36;
    localparam logic [7:0] OP_JNT0 = 8'h26;
    localparam logic [7:0] OP_JT1 = 8'h56;
    localparam logic [7:0] OP_JNT1 = 8'h46;
    localparam logic [7:0] OP_INDIRECT_PAGE_JUMP = 8'hB3;
    // opcode groups matched on the high five bits, the low five bits (jump, bit test) or the high seven bits (indirect increment)
    localparam logic [4:0] GRP_DEC_R = 5'h19;
    localparam logic [4:0] GRP_DECREMENT_BRANCH_NONZERO = 5'h1D;
    localparam logic [4:0] GRP_INC_R = 5'h03;
    localparam logic [6:0] GRP_INC_IND = 7'h08;
    localparam logic [4:0] GRP_JMP_LOW = 5'h04;
    localparam logic [4:0] GRP_JB_LOW = 5'h12;
    // port 2 bit positions
    localparam int P2_OBF_BIT = 4;
    localparam int P2_IBF_BIT = 5;
    localparam int P2_DRQ_BIT = 6;
    localparam int P2_DMA_ACKNOWLEDGE_IN_BIT = 7;
    // widths and reset values
    localparam int PC_W = 11;
    localparam int DMEM_AW = 6;
    localparam logic [7:0] P2_RESET = 8'hFF;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    // execution states, one bit between fetch and operand, both bits between fetch and memory write
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_OPER = 2'b01,
        ST_MEM = 2'b11
    } exec_state_t;
endpackage

// ---- exec_dmem.sv ----
module exec_dmem (
    input wire logic clk,
    input wire logic [exec_pkg::DMEM_AW-1:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [exec_pkg::DMEM_AW-1:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [0:(1<<exec_pkg::DMEM_AW)-1];

    // registered read, plain write
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ---- exec_sync.sv ----
module exec_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [4:0] async_in,
    output logic [4:0] sync_out
);
    logic [4:0] stage1_q;
    logic [4:0] stage2_q;

    // two-flop synchroniser for pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // idle levels: select, write and acknowledge high, test pins low
            stage1_q <= 5'h1_9;
            stage2_q <= 5'h1_9;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end
    assign sync_out = stage2_q;
endmodule

// ---- exec_prog_rom.sv ----
// ==========
// program store
module exec_prog_rom (
    input wire logic [exec_pkg::PC_W-1:0] prog_addr,
    output logic [7:0] prog_data
);
    logic [7:0] mem [0:2047];
    // combinational read, byte seen in the same cycle
    assign prog_data = mem[prog_addr];
endmodule

// ---- exec_checker.sv ----
// ==========
// port checker
module exec_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] prog_data,
    input wire logic host_cs_b,
    input wire logic host_wr_b,
    input wire logic output_buffer_full_flag,
    input wire logic timer_overflow,
    input wire logic port2_bit7,
    input wire logic [7:0] port2_out,
    input wire logic input_buffer_full_flag,
    input wire logic timer_overflow_flag,
    input wire logic irq_start,
    input wire logic dma_request_out,
    input wire logic dma_enabled,
    input wire logic flags_enabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // host write and the flag answer
    sequence host_write_s;
        $fell(host_wr_b) && !host_cs_b;
    endsequence
    sequence ibf_up_s;
        ##[1:6] input_buffer_full_flag;
    endsequence
    chk_ibf_host_set: assert property (host_write_s |-> ibf_up_s)
        else $error("input full flag not set by host write");
    chk_ibf_holds: assert property (
        input_buffer_full_flag && prog_data != exec_pkg::OP_IN_DBB |=> input_buffer_full_flag)
        else $error("input full flag dropped without a read");
    chk_ibf_pin: assert property (flags_enabled && port2_out[5] |-> !input_buffer_full_flag)
        else $error("bit5 high while input buffer full");
    chk_obf_pin: assert property (flags_enabled && port2_out[4] |-> output_buffer_full_flag)
        else $error("bit4 high while output buffer empty");
    chk_drq_pin: assert property (dma_enabled |-> port2_out[6] == dma_request_out)
        else $error("bit6 differs from dma request");
    chk_dma_stays: assert property (dma_enabled |=> dma_enabled)
        else $error("dma enable lost");
    chk_ack_clears: assert property ((dma_enabled && !port2_bit7) [*4] |=> !dma_request_out)
        else $error("dma request not cleared by acknowledge");
    chk_irq_pulse: assert property (irq_start |=> !irq_start)
        else $error("interrupt start longer than one cycle");
    chk_tf_set: assert property (timer_overflow |=> timer_overflow_flag)
        else $error("timer flag not set by overflow");
endmodule
bind peripheral_mcu_instr_exec exec_checker exec_checker_i (.clk, .rst_b, .prog_data, .host_cs_b, .host_wr_b,
    .output_buffer_full_flag, .timer_overflow, .port2_bit7, .port2_out, .input_buffer_full_flag,
    .timer_overflow_flag, .irq_start, .dma_request_out, .dma_enabled, .flags_enabled);

// ---- peripheral_mcu_instr_exec_bench.sv ----
module peripheral_mcu_instr_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, host_cs_b = 1, host_wr_b = 1, host_cd_sel = 0, port2_write = 0;
    logic output_buffer_full_flag = 0, test_input_zero = 0, test_input_one = 0, timer_overflow = 0;
    logic carry_in = 0, user_flag_zero = 0, port2_bit7 = 1;
    logic [7:0] host_data_in = 8'h00, port2_write_data = 8'h00, prog_data, port2_out, accumulator;
    logic [exec_pkg::PC_W-1:0] prog_addr;
    logic input_buffer_full_flag, command_data_flag, timer_overflow_flag, irq_start;
    logic input_irq_pending, timer_irq_pending, dma_request_out, dma_enabled, flags_enabled;
    int mismatches = 0, check_count = 0, irq_cnt = 0, cycles = 0;
    logic [7:0] cj [8] = '{exec_pkg::OP_JC, exec_pkg::OP_JNC, exec_pkg::OP_JF0, exec_pkg::OP_OUTPUT_FULL_JUMP,
        exec_pkg::OP_JT0, exec_pkg::OP_JNT0, exec_pkg::OP_JT1, exec_pkg::OP_JNT1};
    logic [7:0] cpol = 8'h5D;
    // ==========
    // design and program store
    peripheral_mcu_instr_exec peripheral_mcu_instr_exec_i (.clk, .rst_b, .prog_addr, .prog_data, .host_cs_b,
        .host_wr_b, .host_cd_sel, .host_data_in, .output_buffer_full_flag, .test_input_zero, .test_input_one,
        .timer_overflow, .carry_in, .user_flag_zero, .port2_write_data, .port2_write, .port2_bit7, .port2_out,
        .accumulator, .input_buffer_full_flag, .command_data_flag, .timer_overflow_flag, .irq_start,
        .input_irq_pending, .timer_irq_pending, .dma_request_out, .dma_enabled, .flags_enabled);
    exec_prog_rom exec_prog_rom_i (.prog_addr, .prog_data);
    // clock
    always #5 clk = ~clk;
    // interrupt start counter and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!rst_b) irq_cnt <= 0;
        else if (irq_start === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ==========
    // tasks
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task ld(input int a, input logic [63:0] b, input int n);
        for (int i = 0; i < n; i++) exec_prog_rom_i.mem[a+i] = b[8*(n-1-i) +: 8];
    endtask
    // reset held while a fresh program is stored
    task hold();
        @(posedge clk);
        rst_b <= 0;
        for (int i = 0; i < 2048; i++) exec_prog_rom_i.mem[i] = 8'h00;
    endtask
    task start(input int n);
        repeat (2) @(posedge clk);
        rst_b <= 1;
        repeat (n) @(posedge clk);
    endtask
    task hw(input logic [7:0] d, input logic cd);
        @(posedge clk);
        host_data_in <= d;
        host_cd_sel <= cd;
        host_cs_b <= 0;
        host_wr_b <= 0;
        repeat (4) @(posedge clk);
        host_wr_b <= 1;
        host_cs_b <= 1;
    endtask
    task tick_overflow();
        @(posedge clk);
        timer_overflow <= 1;
        @(posedge clk);
        timer_overflow <= 0;
    endtask
    task complete_run();
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        repeat (12) @(posedge clk);
        // count, bit test, loop and fall through
        hold();
        ld(0, 64'h1717_0712_0817_1717, 8);
        ld(8, 56'h32_20E9_0A17_040D, 7);
        ld(32, 8'h07, 1);
        start(800);
        chk("acc_count", 8'h02, accumulator);
        chk("page", 8'h00, {5'h0, prog_addr[10:8]});
        // loop instruction at the last byte of a page
        hold();
        ld(0, 16'h04FF, 2);
        ld(16, 8'h07, 1);
        ld(255, 16'hE810, 2);
        ld(272, 24'h17_2411, 3);
        start(30);
        chk("acc_wrap", 8'h01, accumulator);
        chk("page_wrap", 8'h01, {5'h0, prog_addr[10:8]});
        // indirect jump through the byte at the accumulator
        hold();
        ld(0, 32'h1717_17B3, 4);
        ld(179, 24'h17_04B4, 3);
        start(30);
        chk("acc_indirect", 8'h04, accumulator);
        // conditional jumps at both input levels
        for (int i = 0; i < 8; i++) begin
            for (int v = 0; v < 2; v++) begin
                hold();
                {carry_in, user_flag_zero, output_buffer_full_flag, test_input_zero, test_input_one} <= {5{v[0]}};
                ld(0, {16'h0000, cj[i], 8'h10}, 4);
                ld(4, 16'h0404, 2);
                ld(16, 24'h17_0411, 3);
                start(40);
                chk("cond_jump", {7'h0, v[0] == cpol[i]}, accumulator);
            end
        end
        // host write with the input interrupt off, then on
        hold();
        user_flag_zero <= 0;
        ld(0, 64'h15B6_0504_0122_760A, 8);
        ld(8, 40'h04_0805_040B, 5);
        start(10);
        hw(8'hA5, 1'b1);
        repeat (20) @(posedge clk);
        chk("ibf_set", 8'h01, {7'h0, input_buffer_full_flag});
        chk("in_pend", 8'h01, {7'h0, input_irq_pending});
        chk("irq_off", 8'h00, irq_cnt[7:0]);
        user_flag_zero <= 1;
        repeat (30) @(posedge clk);
        chk("acc_host", 8'hA5, accumulator);
        chk("ibf_clr", 8'h00, {7'h0, input_buffer_full_flag});
        chk("cd_flag", 8'h01, {7'h0, command_data_flag});
        chk("irq_late", 8'h01, {7'h0, irq_cnt != 0});
        hw(8'h3C, 1'b0);
        repeat (20) @(posedge clk);
        chk("irq_on", 8'h01, {7'h0, irq_cnt >= 2});
        // timer interrupt on
        hold();
        ld(0, 24'h25_0401, 3);
        start(10);
        tick_overflow();
        repeat (5) @(posedge clk);
        chk("irq_timer", 8'h01, irq_cnt[7:0]);
        chk("tf_on", 8'h01, {7'h0, timer_overflow_flag});
        // timer interrupt off, then flag jump
        hold();
        user_flag_zero <= 0;
        ld(0, 64'h35B6_0504_0116_1004, 8);
        ld(8, 8'h07, 1);
        ld(16, 24'h17_0411, 3);
        start(10);
        tick_overflow();
        repeat (10) @(posedge clk);
        chk("tf_off", 8'h01, {7'h0, timer_overflow_flag});
        chk("irq_toff", 8'h00, irq_cnt[7:0]);
        chk("t_pend", 8'h00, {7'h0, timer_irq_pending});
        user_flag_zero <= 1;
        repeat (20) @(posedge clk);
        chk("acc_tf", 8'h01, accumulator);
        chk("tf_clr", 8'h00, {7'h0, timer_overflow_flag});
        // flag pins and dma handshake
        hold();
        output_buffer_full_flag <= 1;
        ld(0, 40'hF5_E522_0403, 5);
        start(20);
        chk("pins", 8'h3F, {2'h0, dma_enabled, flags_enabled, dma_request_out, port2_out[6:4]});
        output_buffer_full_flag <= 0;
        repeat (3) @(posedge clk);
        chk("obf_pin", 8'h00, {7'h0, port2_out[4]});
        port2_bit7 <= 0;
        repeat (6) @(posedge clk);
        chk("drq_ack", 8'h00, {7'h0, dma_request_out});
        port2_write_data <= 8'hDF;
        port2_write <= 1;
        @(posedge clk);
        port2_write <= 0;
        repeat (3) @(posedge clk);
        chk("ibf_pin_off", 8'h00, {7'h0, port2_out[5]});
        complete_run();
    end
endmodule
